// ### hdl/das_pkg.sv
// constants, types and register map for the drive alarm supervisor
package das_pkg;
  localparam int NA     = 33;
  localparam int DLY_W  = 16;
  localparam int IDX_W  = 6;
  // alarm positions, number minus one
  localparam int A_FIELD = 0;
  localparam int A_HEAT  = 1;
  localparam int A_ARM   = 2;
  localparam int A_LOAD  = 3;
  localparam int A_UNST  = 5;
  localparam int A_MFAIL = 6;
  localparam int A_LRNG  = 10;
  localparam int A_FRNG  = 11;
  localparam int A_SYNC  = 12;
  localparam int A_RRNG  = 13;
  localparam int A_TERR  = 14;
  localparam int A_OV    = 15;
  localparam int A_UV    = 16;
  localparam int A_TINT  = 17;
  localparam int A_TLIM  = 18;
  localparam int A_NVW   = 24;
  localparam int A_NVB   = 25;
  localparam int A_SER   = 26;
  localparam int A_FB    = 27;
  localparam int A_UCR   = 31;
  localparam int A_UNK   = 32;
  localparam logic [NA-1:0] ONE = {{(NA-1){1'b0}}, 1'b1};
  localparam logic [NA-1:0] NO_AUTO_MASK = (ONE << A_LRNG) | (ONE << A_RRNG) | (ONE << A_TERR)
    | (ONE << A_TINT) | (ONE << A_TLIM) | (ONE << A_NVW) | (ONE << A_NVB) | (ONE << A_UCR)
    | (ONE << A_UNK);
  localparam logic [NA-1:0] MAINS_MASK = (ONE << A_UNST) | (ONE << A_MFAIL) | (ONE << A_FRNG)
    | (ONE << A_SYNC) | (ONE << A_UV);
  // register byte offsets
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_DISABLE = 12'h004;
  localparam logic [11:0] REG_MDLY    = 12'h008;
  localparam logic [11:0] REG_SDLY    = 12'h00c;
  localparam logic [11:0] REG_FDLY    = 12'h010;
  localparam logic [11:0] REG_ACLR    = 12'h014;
  localparam logic [11:0] REG_NOMFLD  = 12'h018;
  localparam logic [11:0] REG_RATED   = 12'h01c;
  localparam logic [11:0] REG_DIFUNC  = 12'h020;
  localparam logic [11:0] REG_STATUS  = 12'h024;
  // field positions and reset values
  localparam int CTRL_POC = 0;
  localparam int CTRL_MAU = 1;
  localparam int CTRL_RSS = 2;
  localparam int ACLR_MIN_LSB = 16;
  localparam int ST_LOCK_BIT  = 8;
  localparam int ST_STORE_BIT = 9;
  localparam int ST_PERM_BIT  = 10;
  localparam int ST_CONS_LSB  = 16;
  localparam logic [31:0] DIFUNC_RST = 32'hffff_ffff;
  localparam logic [3:0]  DI_FUNC_RESET = 4'h0;
  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MS_NS           = 1000000;
  localparam int STORE_HOLD_MS   = 500;
  localparam int AUTOCLR_WAIT_MS = 2000;
  localparam int FIELD_DLY_MS    = 2000;
  // thresholds
  localparam int FIELD_THR_NUM = 75;
  localparam int FIELD_THR_DEN = 1000;
  localparam int OC_NORM_PCT   = 200;
  localparam int OC_LIMIT_PCT  = 300;
  localparam int PCT_DEN       = 100;
  localparam logic [7:0] DISP_LETTER_A = 8'h41;
  localparam logic [7:0] DISP_BLANK    = 8'h20;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_TRIP   = 3'b010,
    ST_AUTO   = 3'b100
  } das_state_t;

  typedef struct packed {
    logic thermo_ok;
    logic load_open;
    logic fuse_blown;
    logic setup_key;
    logic store_key;
    logic power_live;
    logic ctrl_powered;
    logic supply_en;
    logic enable_in;
    logic start_in;
  } das_pins_t;

  typedef struct packed {
    logic [15:0] field_current;
    logic [15:0] arm_peak;
  } das_meas_t;

  typedef struct packed {
    logic [7:0]       letter;
    logic [IDX_W-1:0] num;
    logic [6:0]       seg_tens;
    logic [6:0]       seg_ones;
  } das_disp_t;
endpackage

// ### hdl/das_supervisor.sv
// alarm supervisor: detection, delay, latch, storage, reset and restart gating
// Function
// - on the first qualified alarm, lowest number if several, show its code and lock the drive
// - display shows letter A followed by the alarm number
// - mains over and undervoltage wait the mains delay setting
// - serial and fieldbus alarms wait their own delay settings
// - all other alarms except field failure wait a fixed internal delay
// - disable bank suppresses alarms; a disabled alarm never trips
// - after 0.5 s locked store alarm unless control section unpowered
// - power-on clear selection set skips the nonvolatile store
// - stay locked until reset; reset accepted only when cause gone
// - manual reset from both keys or a reset-programmed digital input
// - nonzero max count auto-resets 2 s after the cause disappears
// - stop auto reset after max consecutive resets inside minimum interval
// - auto reset never clears tuning, range, storage or controller alarms
// - mains auto-clear setting gives unlimited auto reset to mains alarms other than overvoltage
// - restart needs power, no alarm, supply, enable, start, safety choice
// - safety choice also gates restart after a reset cleared an alarm
// - field failure compares field current to 7.5 percent of nominal
// - field failure while running, or with field current seen during tuning, 2 s delay, disableable
// - heatsink alarm trips when the thermal contact opens
// - overcurrent above 200 percent, or 300 percent under overlimit
// - load loss on open load lead or blown fuse, disableable
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module das_supervisor #(
  parameter int MS_CYCLES    = das_pkg::MS_NS / das_pkg::CLK_PERIOD_NS,
  parameter int NDI          = 8,
  parameter int FIXED_DLY_MS = 100
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire das_pkg::das_pins_t       pins,
  input  wire logic [NDI-1:0]           di_in,
  input  wire logic [das_pkg::NA-5:0]   fault_in,
  input  wire das_pkg::das_meas_t       meas,
  input  wire logic                     drive_running,
  input  wire logic                     tuning_active,
  input  wire logic                     overlimit_mode,
  output das_pkg::das_disp_t            disp,
  output logic                          drive_lock,
  output logic                          run_permit,
  output logic                          nv_store_req,
  output logic [das_pkg::IDX_W-1:0]     nv_code
);
  import das_pkg::*;

  localparam int PW = $clog2(MS_CYCLES);
  localparam int SW = $bits(das_pins_t) + NDI + NA - 4;

  // elaboration guard against values the logic cannot serve
  if (MS_CYCLES < 2 || NDI < 1 || NDI > 8 || FIXED_DLY_MS < 0 || FIXED_DLY_MS > 65535) begin : g_bad
    $error("das_supervisor: unsupported parameter value");
  end

  // seven-segment pattern for one decimal digit, segment a in bit 0
  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3f;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5b;
      4'h3: seg7 = 7'h4f;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6d;
      4'h6: seg7 = 7'h7d;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7f;
      4'h9: seg7 = 7'h6f;
      default: seg7 = 7'h00;
    endcase
  endfunction

  // delay limit in ms for each alarm position
  function automatic logic [DLY_W-1:0] lim_ms(input int i, input logic [DLY_W-1:0] md,
                                              input logic [DLY_W-1:0] sd,
                                              input logic [DLY_W-1:0] fd);
    case (i)
      A_OV, A_UV: lim_ms = md;
      A_SER:      lim_ms = sd;
      A_FB:       lim_ms = fd;
      A_FIELD:    lim_ms = DLY_W'(FIELD_DLY_MS);
      default:    lim_ms = DLY_W'(FIXED_DLY_MS);
    endcase
  endfunction

  function automatic logic addr_hit(input logic [11:0] a);
    case (a)
      REG_CTRL, REG_DISABLE, REG_MDLY, REG_SDLY, REG_FDLY, REG_ACLR,
      REG_NOMFLD, REG_RATED, REG_DIFUNC, REG_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  // two-flop synchroniser for every pin-level input
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {pins, di_in, fault_in};
      s2_q <= s1_q;
    end
  end
  das_pins_t        pin_s;
  logic [NDI-1:0]   di_s;
  logic [NA-5:0]    flt_s;
  assign {pin_s, di_s, flt_s} = s2_q;

  // configuration registers
  logic [2:0]       ctrl_q, ctrl_d;
  logic [31:0]      dis_q, dis_d;
  logic [DLY_W-1:0] mdly_q, mdly_d, sdly_q, sdly_d, fdly_q, fdly_d;
  logic [7:0]       acmax_q, acmax_d;
  logic [15:0]      acmin_q, acmin_d;
  logic [15:0]      nom_q, nom_d, rated_q, rated_d;
  logic [31:0]      difn_q, difn_d;
  logic [31:0]      prdata_q, prdata_d;
  logic             hit, wr_en;
  logic [31:0]      rd_val;
  logic             stored_q, stored_d;
  logic [7:0]       consec_q, consec_d;
  das_state_t       st_q, st_d;
  logic             perm_q, perm_d;
  logic [IDX_W-1:0] cidx_q, cidx_d;

  // apb decode; zero wait states, unmapped offsets answer with pslverr
  assign hit     = addr_hit(paddr);
  assign wr_en   = psel & penable & pwrite & hit;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_q;

  always_comb begin
    case (paddr)
      REG_CTRL:    rd_val = {29'h0, ctrl_q};
      REG_DISABLE: rd_val = dis_q;
      REG_MDLY:    rd_val = {16'h0, mdly_q};
      REG_SDLY:    rd_val = {16'h0, sdly_q};
      REG_FDLY:    rd_val = {16'h0, fdly_q};
      REG_ACLR:    rd_val = {acmin_q, 8'h0, acmax_q};
      REG_NOMFLD:  rd_val = {16'h0, nom_q};
      REG_RATED:   rd_val = {16'h0, rated_q};
      REG_DIFUNC:  rd_val = difn_q;
      REG_STATUS:  rd_val = {8'h0, consec_q, 5'h0, perm_q, stored_q, st_q != ST_NORMAL,
                             2'h0, cidx_q};
      default:     rd_val = 32'h0;
    endcase
  end

  // register writes at the access edge; read data latched in setup
  always_comb begin
    ctrl_d   = ctrl_q;
    dis_d    = dis_q;
    mdly_d   = mdly_q;
    sdly_d   = sdly_q;
    fdly_d   = fdly_q;
    acmax_d  = acmax_q;
    acmin_d  = acmin_q;
    nom_d    = nom_q;
    rated_d  = rated_q;
    difn_d   = difn_q;
    prdata_d = (psel && !penable && !pwrite) ? rd_val : prdata_q;
    if (wr_en) begin
      case (paddr)
        REG_CTRL:    ctrl_d = pwdata[2:0];
        REG_DISABLE: dis_d = pwdata;
        REG_MDLY:    mdly_d = pwdata[DLY_W-1:0];
        REG_SDLY:    sdly_d = pwdata[DLY_W-1:0];
        REG_FDLY:    fdly_d = pwdata[DLY_W-1:0];
        REG_ACLR: begin
          acmax_d = pwdata[7:0];
          acmin_d = pwdata[ACLR_MIN_LSB +: 16];
        end
        REG_NOMFLD:  nom_d = pwdata[15:0];
        REG_RATED:   rated_d = pwdata[15:0];
        REG_DIFUNC:  difn_d = pwdata;
        default:     ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q   <= 3'h0;
      dis_q    <= 32'h0;
      mdly_q   <= '0;
      sdly_q   <= '0;
      fdly_q   <= '0;
      acmax_q  <= 8'h00;
      acmin_q  <= 16'h0000;
      nom_q    <= 16'h0000;
      rated_q  <= 16'h0000;
      difn_q   <= DIFUNC_RST;
      prdata_q <= 32'h0;
    end else begin
      ctrl_q   <= ctrl_d;
      dis_q    <= dis_d;
      mdly_q   <= mdly_d;
      sdly_q   <= sdly_d;
      fdly_q   <= fdly_d;
      acmax_q  <= acmax_d;
      acmin_q  <= acmin_d;
      nom_q    <= nom_d;
      rated_q  <= rated_d;
      difn_q   <= difn_d;
      prdata_q <= prdata_d;
    end
  end

  // millisecond tick shared by every delay
  logic [PW-1:0] presc_q, presc_d;
  logic          tick;
  assign tick    = presc_q == PW'(MS_CYCLES - 1);
  assign presc_d = tick ? '0 : presc_q + PW'(1);

  // raw causes for the four locally detected alarms
  logic [31:0]   fthr, ocl;
  logic [NA-1:0] cause, dis_v, qual;
  always_comb begin
    fthr = (32'(nom_q) * 32'(FIELD_THR_NUM)) / 32'(FIELD_THR_DEN);
    ocl  = (32'(rated_q) * 32'(overlimit_mode ? OC_LIMIT_PCT : OC_NORM_PCT)) / 32'(PCT_DEN);
    cause = {flt_s, 4'h0};
    cause[A_FIELD] = (drive_running && 32'(meas.field_current) < fthr)
                   || (tuning_active && 32'(meas.field_current) >= fthr);
    cause[A_HEAT]  = ~pin_s.thermo_ok;
    cause[A_ARM]   = 32'(meas.arm_peak) > ocl;
    cause[A_LOAD]  = pin_s.load_open | pin_s.fuse_blown;
    dis_v = {1'b0, dis_q};
  end

  // per-alarm delay counters in ms, cleared while the cause is absent
  logic [DLY_W-1:0] dly_q [NA];
  logic [DLY_W-1:0] dly_d [NA];
  always_comb begin
    for (int i = 0; i < NA; i++) begin
      dly_d[i] = dly_q[i];
      if (!cause[i]) begin
        dly_d[i] = '0;
      end else if (tick && dly_q[i] != '1) begin
        dly_d[i] = dly_q[i] + DLY_W'(1);
      end
      qual[i] = cause[i] && dly_q[i] >= lim_ms(i, mdly_q, sdly_q, fdly_q) && !dis_v[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      presc_q <= '0;
      for (int i = 0; i < NA; i++) begin
        dly_q[i] <= '0;
      end
    end else begin
      presc_q <= presc_d;
      dly_q   <= dly_d;
    end
  end

  // manual reset: edge of keys pair or reset-programmed input
  logic man_lvl, man_prev_q, man_evt;
  always_comb begin
    // keys pair or input with function 0
    man_lvl = pin_s.setup_key & pin_s.store_key;
    for (int i = 0; i < NDI; i++) begin
      if (di_s[i] && difn_q[4*i +: 4] == DI_FUNC_RESET) begin
        man_lvl = 1'b1;
      end
    end
  end
  assign man_evt = man_lvl & ~man_prev_q;

  // trip, storage and clearing state
  logic [IDX_W-1:0] first;
  logic [DLY_W-1:0] hold_q, hold_d, tmr_q, tmr_d, since_q, since_d;
  logic             store_d, store_q, guard_q, guard_d, cause_now, auto_ok, lock_d;
  logic [IDX_W-1:0] nvc_q, nvc_d;
  das_disp_t        disp_q, disp_d;
  logic [IDX_W-1:0] num;
  assign cause_now = cause[cidx_q];
  assign auto_ok = !NO_AUTO_MASK[cidx_q] && ((ctrl_q[CTRL_MAU] && MAINS_MASK[cidx_q])
                   || (acmax_q != 8'h00 && consec_q < acmax_q));

  always_comb begin
    first = '0;
    for (int i = NA - 1; i >= 0; i--) begin
      if (qual[i]) first = IDX_W'(i);
    end
    st_d     = st_q;
    cidx_d   = cidx_q;
    hold_d   = hold_q;
    tmr_d    = tmr_q;
    stored_d = stored_q;
    store_d  = 1'b0;
    nvc_d    = nvc_q;
    consec_d = consec_q;
    since_d  = (tick && since_q != '1) ? since_q + DLY_W'(1) : since_q;
    guard_d  = pin_s.enable_in ? guard_q : 1'b0;
    if (tick && hold_q != '1) hold_d = hold_q + DLY_W'(1);
    if (tick && tmr_q != '1) tmr_d = tmr_q + DLY_W'(1);
    // one store decision after the hold time
    if (st_q != ST_NORMAL && !stored_q && hold_q >= DLY_W'(STORE_HOLD_MS)) begin
      stored_d = 1'b1;
      store_d  = pin_s.ctrl_powered & ~ctrl_q[CTRL_POC];
      nvc_d    = cidx_q + IDX_W'(1);
    end
    case (st_q)
      ST_NORMAL: begin
        if (|qual) begin
          st_d     = ST_TRIP;
          cidx_d   = first;
          hold_d   = '0;
          stored_d = 1'b0;
        end
      end
      ST_TRIP: begin
        // reset accepted only with the cause gone
        if (man_evt && !cause_now) begin
          st_d     = ST_NORMAL;
          guard_d  = 1'b1;
          consec_d = 8'h00;
        end else if (auto_ok && !cause_now) begin
          st_d  = ST_AUTO;
          tmr_d = '0;
        end
      end
      ST_AUTO: begin
        if (cause_now) begin
          st_d = ST_TRIP;
        end else if (man_evt) begin
          st_d     = ST_NORMAL;
          guard_d  = 1'b1;
          consec_d = 8'h00;
        // auto reset after the wait, counting quick repeats
        end else if (tmr_q >= DLY_W'(AUTOCLR_WAIT_MS)) begin
          st_d     = ST_NORMAL;
          guard_d  = 1'b1;
          since_d  = '0;
          consec_d = (since_q < acmin_q) ? ((consec_q == 8'hff) ? consec_q : consec_q + 8'h01)
                                         : 8'h01;
        end
      end
      default: st_d = ST_NORMAL;
    endcase
    lock_d = st_d != ST_NORMAL;
    num = lock_d ? cidx_d + IDX_W'(1) : '0;
    disp_d.letter   = lock_d ? DISP_LETTER_A : DISP_BLANK;
    disp_d.num      = num;
    disp_d.seg_tens = lock_d ? seg7(4'(num / IDX_W'(10))) : 7'h00;
    disp_d.seg_ones = lock_d ? seg7(4'(num % IDX_W'(10))) : 7'h00;
    // restart gating, safety choice needs an enable off-on
    perm_d = pin_s.power_live && !lock_d && pin_s.supply_en && pin_s.enable_in
             && pin_s.start_in && !(ctrl_q[CTRL_RSS] && guard_d);
  end

  // guard loads set at reset but clears one cycle later while the synchronised enable still reads low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q       <= ST_NORMAL;
      cidx_q     <= '0;
      hold_q     <= '0;
      tmr_q      <= '0;
      since_q    <= '1;
      stored_q   <= 1'b0;
      store_q    <= 1'b0;
      nvc_q      <= '0;
      consec_q   <= 8'h00;
      guard_q    <= 1'b1;
      man_prev_q <= 1'b0;
      disp_q     <= '0;
      perm_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      cidx_q     <= cidx_d;
      hold_q     <= hold_d;
      tmr_q      <= tmr_d;
      since_q    <= since_d;
      stored_q   <= stored_d;
      store_q    <= store_d;
      nvc_q      <= nvc_d;
      consec_q   <= consec_d;
      guard_q    <= guard_d;
      man_prev_q <= man_lvl;
      disp_q     <= disp_d;
      perm_q     <= perm_d;
    end
  end

  assign drive_lock   = st_q != ST_NORMAL;
  assign disp         = disp_q;
  assign run_permit   = perm_q;
  assign nv_store_req = store_q;
  assign nv_code      = nvc_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_new_trip;
    !drive_lock ##1 drive_lock;
  endsequence
  sequence s_no_store;
    !nv_store_req [*8];
  endsequence

  chk_lock_trip: assert property (!drive_lock && |qual |=> drive_lock)
    else $error("alarm did not lock the drive");
  chk_disp_code: assert property (drive_lock |-> disp.letter == DISP_LETTER_A
    && disp.num == cidx_q + IDX_W'(1))
    else $error("display does not show latched alarm");
  chk_mains_delay: assert property ($rose(qual[A_OV]) && mdly_q != '0
    |-> $past(cause[A_OV]))
    else $error("mains alarm tripped without delay");
  chk_serial_delay: assert property ($rose(qual[A_SER]) && sdly_q != '0
    |-> $past(cause[A_SER]))
    else $error("serial alarm tripped without delay");
  chk_field_disable: assert property (dis_q[A_FIELD] |-> !qual[A_FIELD])
    else $error("disabled alarm qualified");
  chk_store_hold: assert property (s_new_trip |-> s_no_store)
    else $error("store before hold time");
  chk_store_gate: assert property (nv_store_req |-> $past(hold_q >= DLY_W'(STORE_HOLD_MS)
    && !ctrl_q[CTRL_POC] && pin_s.ctrl_powered, 1))
    else $error("store issued when it must be skipped");
  chk_reset_cause: assert property ($fell(drive_lock) |-> !$past(cause_now))
    else $error("cleared with cause present");
  chk_no_auto: assert property (st_q == ST_TRIP && NO_AUTO_MASK[cidx_q]
    |=> st_q != ST_AUTO)
    else $error("auto reset on excluded alarm");
  chk_code_kept: assert property (drive_lock && $past(drive_lock) |-> $stable(cidx_q))
    else $error("latched alarm code changed");
  chk_restart: assert property (run_permit |-> !drive_lock && $past(pin_s.enable_in)
    && $past(pin_s.start_in))
    else $error("restart permitted without conditions");
endmodule
`default_nettype wire

// ### tb/das_field_model.sv
// field-side model: keypad, digital inputs and power-section sensors
`timescale 1ns/1ns
`default_nettype none
module das_field_model (
  input  wire logic                sys_clk,
  output var  das_pkg::das_pins_t  pins,
  output var  logic [7:0]          di_in,
  output var  logic [28:0]         fault_in,
  output var  das_pkg::das_meas_t  meas
);
  import das_pkg::*;

  // healthy idle
  // contact closed, power live, supply, enable and start all on
  initial begin
    pins = '0;
    pins.thermo_ok = 1'b1;
    pins.power_live = 1'b1;
    pins.ctrl_powered = 1'b1;
    pins.supply_en = 1'b1;
    pins.enable_in = 1'b1;
    pins.start_in = 1'b1;
    di_in = '0;
    fault_in = '0;
    meas = '0;
  end

  // both keys together
  // held long enough to pass the input synchronisers, then released
  task automatic keys();
    @(posedge sys_clk);
    pins.setup_key <= 1'b1;
    pins.store_key <= 1'b1;
    repeat (5) @(posedge sys_clk);
    pins.setup_key <= 1'b0;
    pins.store_key <= 1'b0;
  endtask

  task automatic di_pulse();
    @(posedge sys_clk);
    di_in[0] <= 1'b1;
    repeat (5) @(posedge sys_clk);
    di_in[0] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the drive alarm supervisor
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import das_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  das_pins_t   pins;
  logic [7:0]  di_in;
  logic [28:0] fault_in;
  das_meas_t   meas;
  das_disp_t   disp;
  logic        drive_lock;
  logic        run_permit;
  logic        drive_running = 1'b0;
  logic        tuning_active = 1'b0;
  logic        overlimit_mode = 1'b0;
  logic        nv_store_req;
  logic [5:0]  nv_code;
  logic [31:0] rdat;
  logic        rerr;
  int          bad_count = 0;
  int          comparisons = 0;
  int          k;

  // short ms tick keeps the long alarm timers affordable
  das_supervisor #(.MS_CYCLES(4), .NDI(8), .FIXED_DLY_MS(2)) i_das_supervisor (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .di_in(di_in), .fault_in(fault_in), .meas(meas),
    .drive_running(drive_running), .tuning_active(tuning_active),
    .overlimit_mode(overlimit_mode), .disp(disp),
    .drive_lock(drive_lock), .run_permit(run_permit), .nv_store_req(nv_store_req),
    .nv_code(nv_code));

  das_field_model i_das_field_model (
    .sys_clk(sys_clk), .pins(pins), .di_in(di_in), .fault_in(fault_in), .meas(meas));

  always #5 sys_clk = ~sys_clk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never completes
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wlock(input logic v, input int n);
    int i;
    for (i = 0; i < n && drive_lock !== v; i++) @(negedge sys_clk);
    check("drive_lock", 32'(drive_lock), 32'(v));
    @(posedge sys_clk);
  endtask

  task automatic wstore(input logic [5:0] code, input logic exp);
    int i;
    int c;
    c = 0;
    for (i = 0; i < 2200; i++) begin
      @(negedge sys_clk);
      if (nv_store_req === 1'b1) begin
        c++;
        check("nv_code", 32'(nv_code), 32'(code));
      end
    end
    check("nv_pulses", 32'(c), 32'(exp));
    @(posedge sys_clk);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog sized well past the longest timer sequence
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, REG_DIFUNC, '0);
    check("difunc", rdat, DIFUNC_RST);
    apb(1'b0, 12'h040, '0);
    check("unmapped", {rdat[30:0], rerr}, 32'h1);
    apb(1'b1, REG_DIFUNC, 32'hffff_fff0);
    apb(1'b1, REG_RATED, 32'd100);
    $display("test registers done");
    i_das_field_model.pins.thermo_ok <= 1'b0;
    wlock(1'b1, 60);
    check("letter", 32'(disp.letter), 32'(DISP_LETTER_A));
    check("num", 32'(disp.num), 32'd2);
    i_das_field_model.fault_in[0] <= 1'b1;
    repeat (30) @(negedge sys_clk);
    check("first_kept", 32'(disp.num), 32'd2);
    wstore(6'd2, 1'b1);
    i_das_field_model.keys();
    repeat (4) @(negedge sys_clk);
    check("lock_held", 32'(drive_lock), 32'd1);
    @(posedge sys_clk);
    i_das_field_model.pins.thermo_ok <= 1'b1;
    i_das_field_model.fault_in[0] <= 1'b0;
    i_das_field_model.keys();
    wlock(1'b0, 12);
    repeat (4) @(negedge sys_clk);
    check("permit", 32'(run_permit), 32'd1);
    $display("test heatsink done");
    apb(1'b1, REG_DISABLE, 32'h8);
    i_das_field_model.pins.load_open <= 1'b1;
    i_das_field_model.meas.arm_peak <= 16'd200;
    repeat (40) @(negedge sys_clk);
    check("quiet", 32'(drive_lock), 32'd0);
    @(posedge sys_clk);
    overlimit_mode <= 1'b1;
    i_das_field_model.meas.arm_peak <= 16'd300;
    repeat (40) @(negedge sys_clk);
    check("quiet_ovl", 32'(drive_lock), 32'd0);
    @(posedge sys_clk);
    overlimit_mode <= 1'b0;
    i_das_field_model.meas.arm_peak <= 16'd201;
    wlock(1'b1, 60);
    check("num", 32'(disp.num), 32'd3);
    i_das_field_model.meas.arm_peak <= '0;
    i_das_field_model.di_pulse();
    wlock(1'b0, 12);
    $display("test disable done");
    apb(1'b1, REG_MDLY, 32'd20);
    i_das_field_model.fault_in[11] <= 1'b1;
    repeat (70) @(negedge sys_clk);
    check("mains_early", 32'(drive_lock), 32'd0);
    wlock(1'b1, 40);
    check("num", 32'(disp.num), 32'd16);
    check("tens", 32'(disp.seg_tens), 32'h06);
    check("ones", 32'(disp.seg_ones), 32'h7d);
    i_das_field_model.fault_in[11] <= 1'b0;
    i_das_field_model.keys();
    wlock(1'b0, 12);
    $display("test mains done");
    // field loss while running, then tuning with current seen keeps the count going
    apb(1'b1, REG_NOMFLD, 32'd1000);
    i_das_field_model.meas.field_current <= 16'd74;
    drive_running <= 1'b1;
    repeat (4000) @(posedge sys_clk);
    i_das_field_model.meas.field_current <= 16'd80;
    drive_running <= 1'b0;
    tuning_active <= 1'b1;
    repeat (3950) @(negedge sys_clk);
    check("field_early", 32'(drive_lock), 32'd0);
    wlock(1'b1, 120);
    check("num", 32'(disp.num), 32'd1);
    tuning_active <= 1'b0;
    i_das_field_model.keys();
    wlock(1'b0, 12);
    $display("test field done");
    apb(1'b1, REG_ACLR, 32'hffff_0002);
    apb(1'b1, REG_CTRL, 32'h4);
    // two quick auto resets allowed, the third trip stays latched
    for (k = 0; k < 3; k++) begin
      i_das_field_model.fault_in[0] <= 1'b1;
      wlock(1'b1, 60);
      i_das_field_model.fault_in[0] <= 1'b0;
      repeat (8100) @(negedge sys_clk);
      check("auto", 32'(drive_lock), 32'(k == 2));
      @(posedge sys_clk);
    end
    apb(1'b0, REG_STATUS, '0);
    check("status", rdat, 32'h0002_0304);
    i_das_field_model.keys();
    wlock(1'b0, 12);
    repeat (4) @(negedge sys_clk);
    check("guarded", 32'(run_permit), 32'd0);
    @(posedge sys_clk);
    i_das_field_model.pins.enable_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
    i_das_field_model.pins.enable_in <= 1'b1;
    repeat (5) @(negedge sys_clk);
    check("rearmed", 32'(run_permit), 32'd1);
    $display("test autoreset done");
    @(posedge sys_clk);
    i_das_field_model.fault_in[6] <= 1'b1;
    wlock(1'b1, 60);
    i_das_field_model.fault_in[6] <= 1'b0;
    repeat (8100) @(negedge sys_clk);
    check("no_auto", 32'(drive_lock), 32'd1);
    i_das_field_model.keys();
    wlock(1'b0, 12);
    $display("test excluded done");
    apb(1'b1, REG_CTRL, 32'h1);
    i_das_field_model.pins.thermo_ok <= 1'b0;
    wlock(1'b1, 60);
    wstore(6'd2, 1'b0);
    $display("test power_on_clear done");
    final_report();
  end
endmodule
`default_nettype wire
